//--- eep_cnt.sv
`timescale 1ns/1ps
`default_nettype none
module eep_cnt #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         clk_en_i,
  // Control
  input  wire logic         clr_i,
  // Count
  output logic [W-1:0]      cnt_o
);

  logic [W-1:0] cnt_ff;
  wire          sat = &cnt_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (clk_en_i) begin
      if (clr_i) begin
        cnt_ff <= '0;
      end else if (!sat) begin
        cnt_ff <= cnt_ff + W'(1);
      end
    end
  end

  assign cnt_o = cnt_ff;

endmodule
`default_nettype wire

//--- eep_host.sv
// Operation
// RULE_01: CE+OE low with WE high reads; CE+WE low with OE high writes; CE high idles.
// RULE_02: Device ignores writes while OE is low or WE is high.
// RULE_03: Up to 32 consecutive byte loads form one page before programming.
// RULE_04: Programming lasts typically 3 ms; host gives up polling after 5 ms.
// RULE_05: Completion is found by polling, no interrupt line.
// RULE_06: Between loads strobes may idle high without disturbing the page.
// RULE_07: CE low with WE high between loads acts as a status poll read.
// RULE_08: Wait 1 ms after power-up before reads, 5 ms before writes.
// RULE_09: Device latches address and data and times programming itself.
// RULE_10: A write is one logic-level WE pulse, no command sequence.
// RULE_11: During programming bit 7 of the last byte reads inverted.
// RULE_12: Each next load must fall within 100 us of the previous WE fall.
// RULE_13: All loads of one page share address bits 12 down to 5.
// RULE_14: Address latches on later falling strobe, data on earlier rising one.
// RULE_15: Thirteen address lines select 8192 bytes over an eight-bit data bus.
// RULE_16: During programming only polling reads are issued, no writes.
`timescale 1ns/1ps
`default_nettype none
module eep_host #(
  parameter int          ADDR_W  = eep_pkg::ADDR_W,
  parameter int          DATA_W  = eep_pkg::DATA_W,
  parameter logic [23:0] BLC_CYC = eep_pkg::BLC_CYC,
  parameter logic [23:0] WC_CYC  = eep_pkg::WC_CYC,
  parameter logic [23:0] PUR_CYC = eep_pkg::PUR_CYC,
  parameter logic [23:0] PUW_CYC = eep_pkg::PUW_CYC
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              clk_en_i,
  // Command port
  input  wire logic              cmd_valid_i,
  output logic                   cmd_ready_o,
  input  wire logic              cmd_write_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DATA_W-1:0] cmd_wdata_i,
  // Answers
  output logic                   rd_valid_o,
  output logic [DATA_W-1:0]      rd_data_o,
  output logic                   wr_done_o,
  output logic                   wr_timeout_o,
  output logic                   busy_o,
  // Memory pins
  output logic                   eep_ce_n_o,
  output logic                   eep_oe_n_o,
  output logic                   eep_we_n_o,
  output logic [ADDR_W-1:0]      eep_addr_o,
  output logic [DATA_W-1:0]      eep_data_o,
  output logic                   eep_data_oe_o,
  input  wire logic [DATA_W-1:0] eep_data_i
);

  localparam int PG_W = ADDR_W - int'(eep_pkg::PAGE_LSB);

  eep_pkg::eep_state_t state_ff;
  eep_pkg::eep_state_t nxt_state;

  logic [7:0]        ph_cnt;
  logic [23:0]       win_cnt;
  logic [23:0]       pwr_cnt;
  logic [DATA_W-1:0] din_s1_ff;
  logic [DATA_W-1:0] din_s2_ff;
  logic [PG_W-1:0]   page_ff;
  logic [5:0]        page_n_ff;
  logic [ADDR_W-1:0] last_addr_ff;
  logic              last_d7_ff;
  logic              poll_d7_ff;
  logic              ce_n_ff;
  logic              oe_n_ff;
  logic              we_n_ff;
  logic              doe_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] dout_ff;
  logic              rd_valid_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic              wr_done_ff;
  logic              wr_to_ff;

  // Decode of the current state and phase
  wire in_idle   = state_ff == eep_pkg::ST_IDLE;
  wire in_page   = state_ff == eep_pkg::ST_PAGE;
  wire ph_setup  = ph_cnt == eep_pkg::SETUP_CYC - 8'h01;
  wire ph_wp     = ph_cnt == eep_pkg::WP_CYC - 8'h01;
  wire ph_wph    = ph_cnt == eep_pkg::WPH_CYC - 8'h01;
  wire ph_acc    = ph_cnt == eep_pkg::ACC_CYC - 8'h01;
  wire ph_rec    = ph_cnt == eep_pkg::REC_CYC - 8'h01;
  wire same_page = cmd_addr_i[ADDR_W-1:eep_pkg::PAGE_LSB] == page_ff;
  wire win_open  = win_cnt < (BLC_CYC - eep_pkg::GUARD_CYC);
  wire win_gone  = win_cnt >= BLC_CYC;
  wire poll_ok   = poll_d7_ff == last_d7_ff;
  wire poll_late = win_cnt >= WC_CYC;

  // Acceptance of commands
  wire pwr_ok    = cmd_write_i ? (pwr_cnt >= PUW_CYC) : (pwr_cnt >= PUR_CYC); // RULE_08
  wire idle_ok   = in_idle && pwr_ok;
  wire page_ok   = in_page && cmd_write_i && same_page && win_open            // RULE_12 RULE_13
                   && (page_n_ff < eep_pkg::PAGE_BYTES);                      // RULE_03
  wire accept    = cmd_valid_i && (idle_ok || page_ok) && clk_en_i;
  wire acc_write = accept && cmd_write_i;
  wire enter_poll = in_page && win_gone;                                      // RULE_16
  wire poll_end  = (state_ff == eep_pkg::ST_P_GAP) && ph_rec;

  assign cmd_ready_o = idle_ok || page_ok;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      eep_pkg::ST_IDLE: begin
        if (accept) begin
          nxt_state = cmd_write_i ? eep_pkg::ST_W_SETUP : eep_pkg::ST_RD;
        end
      end
      eep_pkg::ST_W_SETUP: begin
        if (ph_setup) begin
          nxt_state = eep_pkg::ST_W_PULSE;
        end
      end
      eep_pkg::ST_W_PULSE: begin
        if (ph_wp) begin
          nxt_state = eep_pkg::ST_W_HOLD;
        end
      end
      eep_pkg::ST_W_HOLD: begin
        if (ph_wph) begin
          nxt_state = eep_pkg::ST_PAGE;
        end
      end
      eep_pkg::ST_PAGE: begin
        if (acc_write) begin
          nxt_state = eep_pkg::ST_W_SETUP;
        end else if (enter_poll) begin
          nxt_state = eep_pkg::ST_P_RD;
        end
      end
      eep_pkg::ST_P_RD: begin
        if (ph_acc) begin
          nxt_state = eep_pkg::ST_P_GAP;
        end
      end
      eep_pkg::ST_P_GAP: begin
        if (ph_rec) begin
          nxt_state = (poll_ok || poll_late) ? eep_pkg::ST_IDLE : eep_pkg::ST_P_RD; // RULE_04 RULE_05
        end
      end
      eep_pkg::ST_RD: begin
        if (ph_acc) begin
          nxt_state = eep_pkg::ST_RD_GAP;
        end
      end
      eep_pkg::ST_RD_GAP: begin
        if (ph_rec) begin
          nxt_state = eep_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = eep_pkg::ST_IDLE;
      end
    endcase
  end

  // Pin levels follow the next state
  wire nxt_wpulse = nxt_state == eep_pkg::ST_W_PULSE;
  wire nxt_rd     = (nxt_state == eep_pkg::ST_P_RD) || (nxt_state == eep_pkg::ST_RD);   // RULE_07
  wire nxt_ce_n   = !(nxt_wpulse || nxt_rd);                    // RULE_01 RULE_06
  wire nxt_we_n   = !nxt_wpulse;                                // RULE_10 RULE_14
  wire nxt_oe_n   = !nxt_rd;                                    // RULE_01
  wire nxt_doe    = (nxt_state == eep_pkg::ST_W_SETUP) || nxt_wpulse
                    || (nxt_state == eep_pkg::ST_W_HOLD);
  wire ph_clr     = nxt_state != state_ff;
  wire win_clr    = (nxt_wpulse && !(state_ff == eep_pkg::ST_W_PULSE)) || enter_poll;

  // Timers: phase, load window or poll budget, power-up
  eep_cnt #(.W(8)) u_ph (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .clr_i     (ph_clr),
    .cnt_o     (ph_cnt)
  );

  eep_cnt #(.W(24)) u_win (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .clr_i     (win_clr),
    .cnt_o     (win_cnt)
  );

  eep_cnt #(.W(24)) u_pwr (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .clr_i     (1'b0),
    .cnt_o     (pwr_cnt)
  );

  // State and pins
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= eep_pkg::ST_IDLE;
      ce_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      doe_ff   <= 1'b0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      ce_n_ff  <= nxt_ce_n;
      oe_n_ff  <= nxt_oe_n;
      we_n_ff  <= nxt_we_n;
      doe_ff   <= nxt_doe;
    end
  end

  // Address, data and page bookkeeping
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_ff      <= '0;
      dout_ff      <= '0;
      page_ff      <= '0;
      page_n_ff    <= 6'h00;
      last_addr_ff <= '0;
      last_d7_ff   <= 1'b0;
    end else if (clk_en_i) begin
      if (accept) begin
        addr_ff <= cmd_addr_i;
        dout_ff <= cmd_wdata_i;
      end else if (enter_poll) begin
        addr_ff <= last_addr_ff;                                // RULE_07 RULE_11
      end
      if (acc_write) begin
        page_ff      <= cmd_addr_i[ADDR_W-1:eep_pkg::PAGE_LSB]; // RULE_13
        page_n_ff    <= in_page ? page_n_ff + 6'h01 : 6'h01;    // RULE_03
        last_addr_ff <= cmd_addr_i;
        last_d7_ff   <= cmd_wdata_i[DATA_W-1];
      end else if (enter_poll) begin
        page_n_ff <= 6'h00;
      end
    end
  end

  // Data pin synchroniser, sampling and answers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      din_s1_ff   <= '0;
      din_s2_ff   <= '0;
      poll_d7_ff  <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
      wr_done_ff  <= 1'b0;
      wr_to_ff    <= 1'b0;
    end else if (clk_en_i) begin
      din_s1_ff   <= eep_data_i;
      din_s2_ff   <= din_s1_ff;
      rd_valid_ff <= (state_ff == eep_pkg::ST_RD) && ph_acc;
      wr_done_ff  <= poll_end && poll_ok;                       // RULE_05 RULE_11
      wr_to_ff    <= poll_end && !poll_ok && poll_late;         // RULE_04
      if ((state_ff == eep_pkg::ST_P_RD) && ph_acc) begin
        poll_d7_ff <= din_s2_ff[DATA_W-1];                      // RULE_11
      end
      if ((state_ff == eep_pkg::ST_RD) && ph_acc) begin
        rd_data_ff <= din_s2_ff;
      end
    end
  end

  assign busy_o        = !in_idle;
  assign rd_valid_o    = rd_valid_ff;
  assign rd_data_o     = rd_data_ff;
  assign wr_done_o     = wr_done_ff;
  assign wr_timeout_o  = wr_to_ff;
  assign eep_ce_n_o    = ce_n_ff;
  assign eep_oe_n_o    = oe_n_ff;
  assign eep_we_n_o    = we_n_ff;
  assign eep_addr_o    = addr_ff;
  assign eep_data_o    = dout_ff;
  assign eep_data_oe_o = doe_ff;

  // Checks
  localparam int A_WPM1 = eep_pkg::WP_CYC - 1;

  default clocking cb @(posedge sys_clk_i iff clk_en_i); endclocking
  default disable iff (rst_i);

  sequence s_we_low;
    !eep_we_n_o && !eep_ce_n_o ##A_WPM1 !eep_we_n_o;
  endsequence

  sequence s_we_release;
    eep_we_n_o && eep_ce_n_o && eep_data_oe_o;
  endsequence

  a_read_strobes:   assert property (!eep_oe_n_o |-> eep_we_n_o && !eep_ce_n_o) // RULE_01
    else $error("read strobes overlap a write");
  a_bus_no_fight:   assert property (eep_data_oe_o |-> eep_oe_n_o) // RULE_01
    else $error("data driven while output enable low");
  a_we_pulse:       assert property ($fell(eep_we_n_o) |-> s_we_low ##1 s_we_release) // RULE_10
    else $error("write pulse width wrong");
  a_quiet_between:  assert property (in_page |-> eep_ce_n_o && eep_we_n_o && eep_oe_n_o) // RULE_06
    else $error("strobes active between loads");
  a_poll_read:      assert property (state_ff == eep_pkg::ST_P_RD |-> eep_addr_o == last_addr_ff && eep_we_n_o) // RULE_07
    else $error("poll not a read of last byte");
  a_pwr_write:      assert property ($fell(eep_we_n_o) |-> pwr_cnt >= PUW_CYC) // RULE_08
    else $error("write too soon after power-up");
  a_pwr_read:       assert property ($fell(eep_oe_n_o) |-> pwr_cnt >= PUR_CYC) // RULE_08
    else $error("read too soon after power-up");
  a_load_window:    assert property ($fell(eep_we_n_o) && page_n_ff > 6'h01 |-> $past(win_cnt) < BLC_CYC) // RULE_12
    else $error("byte load window exceeded");
  a_same_page:      assert property ($fell(eep_we_n_o) && page_n_ff > 6'h01 |-> eep_addr_o[ADDR_W-1:eep_pkg::PAGE_LSB] == $past(page_ff, 4)) // RULE_13
    else $error("page address changed within page");
  a_page_limit:     assert property (page_n_ff <= eep_pkg::PAGE_BYTES) // RULE_03
    else $error("page holds too many bytes");
  a_no_write_busy:  assert property (state_ff == eep_pkg::ST_P_GAP |-> ##1 eep_we_n_o) // RULE_16
    else $error("write issued while programming");
  a_poll_timeout:   assert property (wr_timeout_o |-> $past(win_cnt) >= WC_CYC && !$past(poll_ok)) // RULE_04
    else $error("timeout raised early");

endmodule
`default_nettype wire

//--- eep_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module eep_mem_model #(
  parameter int BLC_P = 200,
  parameter int PUR_P = 20,
  parameter int PUW_P = 40
) (
  // Clock and power-on
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Device pins
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [7:0]  host_data_i,
  input  wire logic        host_oe_i,
  // Programming time in cycles
  input  wire logic [31:0] prog_cyc_i,
  // Bus level and protocol flag
  output logic [7:0]       bus_o,
  output logic             viol_o
);
  logic [7:0]  mem [8192];
  logic [7:0]  pg_data [32];
  logic [31:0] pg_mask;
  logic [12:0] last_a;
  logic [7:0]  last_d;
  logic [7:0]  prev_bus;
  logic        wr_on;
  logic [31:0] pwr;
  logic [31:0] win;
  logic [31:0] prog;
  wire         rd_on = !ce_n_i && !oe_n_i && we_n_i;
  wire         wr_lo = !ce_n_i && oe_n_i && !we_n_i;

  initial begin
    for (int k = 0; k < 8192; k++) mem[k] = 8'hFF;
    prev_bus = 8'h00;
    viol_o = 1'b0;
  end

  // Floating bus shows a changing pattern, never the last value
  always_comb begin
    if (host_oe_i) bus_o = host_data_i;
    else if (rd_on && prog != 0 && addr_i == last_a) bus_o = {~last_d[7], last_d[6:0]};
    else if (rd_on) bus_o = mem[addr_i];
    else bus_o = ~prev_bus;
  end

  always @(posedge sys_clk_i) begin
    prev_bus <= bus_o;
    viol_o <= 1'b0;
    if (rst_i) begin
      pwr <= 0;
      win <= 0;
      prog <= 0;
      wr_on <= 1'b0;
      pg_mask <= 0;
    end else begin
      pwr <= pwr + 1;
      if ((rd_on && pwr < PUR_P) || (wr_lo && pwr < PUW_P)) viol_o <= 1'b1;
      if ((!oe_n_i && !we_n_i) || (rd_on && host_oe_i)) viol_o <= 1'b1;
      if (prog != 0) prog <= prog - 1;
      if (prog == 1) begin
        for (int k = 0; k < 32; k++) if (pg_mask[k]) mem[{last_a[12:5], 5'(k)}] <= pg_data[k];
        pg_mask <= 0;
      end
      if (wr_lo && !wr_on) begin
        wr_on <= (prog == 0);
        last_a <= addr_i;
        win <= 1;
        if (prog != 0) viol_o <= 1'b1;
        if (pg_mask != 0 && addr_i[12:5] != last_a[12:5]) viol_o <= 1'b1;
      end else if (win != 0 && win < BLC_P) begin
        win <= win + 1;
      end else if (win >= BLC_P && !wr_on) begin
        win <= 0;
        prog <= prog_cyc_i;
      end
      if (wr_on && !wr_lo) begin
        wr_on <= 1'b0;
        pg_data[last_a[4:0]] <= host_data_i;
        pg_mask[last_a[4:0]] <= 1'b1;
        last_d <= host_data_i;
        if (!host_oe_i) viol_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- eep_pkg.sv
package eep_pkg;

  // Geometry
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PAGE_LSB   = 5;
  localparam logic [5:0]  PAGE_BYTES = 6'h20;
  localparam int unsigned SYNC_CYC   = 2;

  // Clock rate
  localparam int unsigned CLK_MHZ = 250;

  // Times in their own units
  localparam int unsigned T_OES_NS  = 10;
  localparam int unsigned T_WP_NS   = 100;
  localparam int unsigned T_WPH_NS  = 50;
  localparam int unsigned T_ACC_NS  = 180;
  localparam int unsigned T_HZ_NS   = 50;
  localparam int unsigned T_BLC_US  = 100;
  localparam int unsigned T_WC_MS   = 5;
  localparam int unsigned T_PUR_MS  = 1;
  localparam int unsigned T_PUW_MS  = 5;

  // Short counts, least times rounded up
  localparam logic [7:0] SETUP_CYC = 8'((T_OES_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WP_CYC    = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WPH_CYC   = 8'((T_WPH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] ACC_CYC   = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC);
  localparam logic [7:0] REC_CYC   = 8'((T_HZ_NS * CLK_MHZ + 999) / 1000);

  // Long counts
  localparam logic [23:0] BLC_CYC   = 24'(T_BLC_US * CLK_MHZ);
  localparam logic [23:0] WC_CYC    = 24'(T_WC_MS * 1000 * CLK_MHZ);
  localparam logic [23:0] PUR_CYC   = 24'(T_PUR_MS * 1000 * CLK_MHZ);
  localparam logic [23:0] PUW_CYC   = 24'(T_PUW_MS * 1000 * CLK_MHZ);
  localparam logic [23:0] GUARD_CYC = 24'(SETUP_CYC) + 24'h000002;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_W_SETUP = 4'h1,
    ST_W_PULSE = 4'h2,
    ST_W_HOLD  = 4'h3,
    ST_PAGE    = 4'h4,
    ST_P_RD    = 4'h5,
    ST_P_GAP   = 4'h6,
    ST_RD      = 4'h7,
    ST_RD_GAP  = 4'h8
  } eep_state_t;

endpackage

//--- parallel_eeprom_page_write_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_eeprom_page_write_tb_top;
  localparam logic [23:0] BLC = 24'h0000C8;
  localparam logic [23:0] WC  = 24'h0007D0;
  localparam logic [23:0] PUR = 24'h000014;
  localparam logic [23:0] PUW = 24'h000028;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic        cmd_valid_i = 1'b0;
  logic        cmd_write_i = 1'b0;
  logic [12:0] cmd_addr_i = 13'h0000;
  logic [7:0]  cmd_wdata_i = 8'h00;
  logic        cmd_ready_o, rd_valid_o, wr_done_o, wr_timeout_o, busy_o;
  logic        ce_n, oe_n, we_n, data_oe, viol;
  logic [7:0]  rd_data_o, data_o, bus;
  logic [12:0] addr_o, a;
  logic [7:0]  pg;
  logic [31:0] prog_cyc = 32'd600;
  logic [9:0]  exp_q [$];
  logic [7:0]  exp_mem [8192];
  int          failures = 0, checks = 0, seed = 97, cyc = 0, i, k;

  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= rst_i ? 0 : cyc + 1;

  eep_host #(.BLC_CYC(BLC), .WC_CYC(WC), .PUR_CYC(PUR), .PUW_CYC(PUW)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
    .cmd_wdata_i(cmd_wdata_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .wr_done_o(wr_done_o),
    .wr_timeout_o(wr_timeout_o), .busy_o(busy_o), .eep_ce_n_o(ce_n), .eep_oe_n_o(oe_n),
    .eep_we_n_o(we_n), .eep_addr_o(addr_o), .eep_data_o(data_o), .eep_data_oe_o(data_oe),
    .eep_data_i(bus));

  eep_mem_model #(.BLC_P(200), .PUR_P(20), .PUW_P(40)) mem (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .addr_i(addr_o), .host_data_i(data_o), .host_oe_i(data_oe), .prog_cyc_i(prog_cyc),
    .bus_o(bus), .viol_o(viol));

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Results are compared in order of issue
  always @(posedge sys_clk_i) begin
    #1;
    if (rd_valid_o === 1'b1 || wr_done_o === 1'b1 || wr_timeout_o === 1'b1) begin
      check({wr_timeout_o, wr_done_o, rd_valid_o ? rd_data_o : 8'h00},
            exp_q.size() > 0 ? exp_q.pop_front() : 10'h3FF);
    end
    if (viol === 1'b1) check({9'h000, viol}, 10'h000);
  end

  // Request held until taken; valid left high for back-to-back use
  task automatic cmd(input logic wr, input logic [12:0] ad, input logic [7:0] d);
    int n;
    cmd_write_i = wr;
    cmd_addr_i = ad;
    cmd_wdata_i = d;
    cmd_valid_i = 1'b1;
    for (n = 0; n < 20000 && !(cmd_ready_o === 1'b1 && clk_en_i); n++) @(posedge sys_clk_i) #1;
    if (n == 20000) begin
      check(10'h000, 10'h3FF);
      complete_run();
    end
    @(posedge sys_clk_i) #1;
  endtask

  task automatic rd(input logic [12:0] ad);
    exp_q.push_back({2'b00, exp_mem[ad]});
    cmd(1'b0, ad, 8'h00);
  endtask

  task automatic drain(input string name);
    int n;
    for (n = 0; n < 20000 && exp_q.size() > 0; n++) @(posedge sys_clk_i) #1;
    if (n == 20000) begin
      check(10'h000, 10'h3FF);
      complete_run();
    end
    $display("test %s done", name);
  endtask

  task automatic page_wr(input logic [7:0] p, input int nb, input int frz, input logic [9:0] fin);
    logic [7:0] d;
    for (int j = 0; j < nb; j++) begin
      d = 8'($random(seed));
      exp_mem[{p, 5'(j)}] = d;
      cmd(1'b1, {p, 5'(j)}, d);
      if (j == frz) begin
        cmd_valid_i = 1'b0;
        clk_en_i = 1'b0;
        repeat (8) @(posedge sys_clk_i) #1;
        clk_en_i = 1'b1;
      end
    end
    cmd_valid_i = 1'b0;
    @(posedge sys_clk_i) #1;
    exp_q.push_back(fin);
  endtask

  initial begin
    for (i = 0; i < 8192; i++) exp_mem[i] = 8'hFF;
    repeat (4) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    check({8'h00, busy_o, cmd_ready_o}, 10'h000);
    // First write waits for power-up, then a read queued behind programming
    a = 13'($random(seed));
    exp_mem[a] = 8'h5A;
    cmd(1'b1, a, 8'h5A);
    check({9'h000, cyc >= PUW && cyc <= PUW + 2}, 10'h001);
    check({9'h000, busy_o}, 10'h001);
    exp_q.push_back(10'h100);
    rd(a);
    cmd_valid_i = 1'b0;
    drain("single_byte");
    // Full pages, prompt and slow programming, clock stalled mid-page
    for (k = 0; k < 2; k++) begin
      prog_cyc = k == 0 ? 32'd5 : 32'd1500;
      pg = 8'($random(seed));
      page_wr(pg, 32, 10, 10'h100);
      for (i = 0; i < 32; i++) rd({pg, 5'(i)});
      cmd_valid_i = 1'b0;
      drain("full_page");
    end
    // Programming longer than the budget gives a timeout
    prog_cyc = 32'd3000;
    pg = 8'($random(seed));
    page_wr(pg, 2, -1, 10'h200);
    drain("timeout");
    repeat (1500) @(posedge sys_clk_i) #1;
    prog_cyc = 32'd600;
    rd({pg, 5'h00});
    rd({pg, 5'h01});
    cmd_valid_i = 1'b0;
    drain("after_timeout");
    complete_run();
  end
endmodule
`default_nettype wire
